// ---- rtl/dbsm_pkg.sv ----
package dbsm_pkg;
    // Sample path
    localparam int SAMPLE_W = 24;
    localparam int BOOST_HEAD = 3;
    localparam int CHAN_N = 2;
    localparam int BUF_DEPTH = 2;
    // Register map (byte addresses)
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_AIF_CFG = 8'h18;
    localparam logic [7:0] OFF_SIDE_CTL = 8'h1c;
    localparam logic [7:0] OFF_STATUS = 8'h20;
    localparam logic [7:0] OFF_COUNT = 8'h24;
    // Interface config fields
    localparam int BOOST_LSB = 0;
    localparam int LSEL_BIT = 5;
    localparam int RSEL_BIT = 4;
    // Sidetone control fields
    localparam int LATT_LSB = 8;
    localparam int RATT_LSB = 4;
    localparam int LSRC_LSB = 2;
    localparam int RSRC_LSB = 0;
    // Status fields
    localparam int ST_CLIP_LSB = 0;
    localparam int ST_MATCH_BIT = 2;
    localparam int ST_LEVEL_LSB = 4;
    // Reset values
    localparam logic [1:0] BOOST_RST = 2'h0;
    localparam logic LSEL_RST = 1'b0;
    localparam logic RSEL_RST = 1'b1;
    localparam logic [3:0] ATT_RST = 4'h0;
    localparam logic [1:0] SRC_RST = 2'h0;
    // Sidetone source codes
    localparam logic [1:0] SRC_NONE = 2'h0;
    localparam logic [1:0] SRC_ADC_LEFT = 2'h1;
    localparam logic [1:0] SRC_ADC_RIGHT = 2'h2;
    // Attenuation coefficients, Q1.15
    localparam int COEF_FRAC = 15;
    localparam int COEF_W = 17;
    localparam logic [3:0] ATT_UNITY = 4'hc;
endpackage : dbsm_pkg

// ---- rtl/dbsm_pair_buf.sv ----
`timescale 1ns/1ps
module dbsm_pair_buf
    import dbsm_pkg::*;
#(
    parameter int WIDTH = 2 * SAMPLE_W,
    parameter int DEPTH = BUF_DEPTH
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int CNT_W = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] slot_reg [DEPTH];
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic [CNT_W-1:0] wpos;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign count_next = count_reg + CNT_W'(push) - CNT_W'(pop);
    assign wpos = count_reg - CNT_W'(pop);
    assign out_data = slot_reg[0];
    assign level = count_reg;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            count_reg <= '0;
            out_valid <= 1'b0;
            in_ready <= 1'b1;
        end else begin
            count_reg <= count_next;
            out_valid <= (count_next != '0);
            in_ready <= (count_next != CNT_W'(DEPTH));
        end
    end

    // Shift toward the head so the output is always slot zero
    for (genvar i = 0; i < DEPTH; i++) begin : g_slot
        always_ff @(posedge clk_sys) begin
            if (push && wpos == CNT_W'(i)) begin
                slot_reg[i] <= in_data;
            end else if (pop && i < DEPTH - 1) begin
                slot_reg[i] <= slot_reg[(i + 1) % DEPTH];
            end
        end
    end
endmodule : dbsm_pair_buf

// ---- rtl/dbsm_side_atten.sv ----
`timescale 1ns/1ps
module dbsm_side_atten
    import dbsm_pkg::*;
#(
    parameter int W = SAMPLE_W
) (
    input wire logic signed [W-1:0] sample,
    input wire logic [3:0] code,
    output logic signed [W-1:0] scaled
);
    logic signed [COEF_W-1:0] coef;
    logic signed [W+COEF_W-1:0] prod;

    // 3 dB steps from -36 dB
    always_comb begin
        unique case (code)
            4'h0: coef = 17'sh00207;
            4'h1: coef = 17'sh002de;
            4'h2: coef = 17'sh0040c;
            4'h3: coef = 17'sh005b8;
            4'h4: coef = 17'sh00814;
            4'h5: coef = 17'sh00b68;
            4'h6: coef = 17'sh0101d;
            4'h7: coef = 17'sh016c3;
            4'h8: coef = 17'sh02027;
            4'h9: coef = 17'sh02d6b;
            4'ha: coef = 17'sh04027;
            4'hb: coef = 17'sh05a9e;
            default: coef = 17'sh08000;
        endcase
    end

    assign prod = sample * coef;

    // Codes from unity upward pass the sample exactly
    always_comb begin
        if (code >= ATT_UNITY) begin
            scaled = sample;
        end else begin
            scaled = prod[COEF_FRAC+W-1:COEF_FRAC];
        end
    end
endmodule : dbsm_side_atten

// ---- rtl/dbsm_top.sv ----
// Notes on behaviour
// - Each playback sample is scaled by a 2-bit boost: x1, +6dB, +12dB or +18dB, reset x1.
// - Sidetone is mixed only while ADC and DAC share one sample rate, with no rate conversion.
// - Each DAC channel gets the playback sample plus its sidetone, one sum per sample period.
// - Sidetone samples come from the ADC high-pass filter output, not raw decimated data.
// - Left sidetone source is bits 3:2, reset 00: none, left ADC, right ADC, 11 reserved.
// - Right sidetone source is bits 1:0, reset 00, with the same encoding.
// - Left sidetone attenuation is bits 11:8, reset 0000: -36dB plus 3dB a step, 11XX is 0dB.
// - Right sidetone attenuation is bits 7:4, reset 0000, with the same encoding.
// - Bit 5 picks the left DAC interface channel, bit 4 the right: 0 left, 1 right.
`timescale 1ns/1ps
module dbsm_top
    import dbsm_pkg::*;
#(
    parameter int W = SAMPLE_W,
    parameter int DEPTH = BUF_DEPTH
) (
    input wire logic clk_sys,
    input wire logic reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Playback samples from the serial interface receiver
    input wire logic signed [W-1:0] play_left_sample,
    input wire logic signed [W-1:0] play_right_sample,
    input wire logic play_valid,
    output logic play_ready,
    // High-pass filtered ADC samples
    input wire logic signed [W-1:0] side_left_sample,
    input wire logic signed [W-1:0] side_right_sample,
    input wire logic side_valid,
    input wire logic rates_match,
    // Mixed samples toward the DACs
    output logic signed [W-1:0] dac_left_sample,
    output logic signed [W-1:0] dac_right_sample,
    output logic dac_valid,
    input wire logic dac_ready
);
    localparam int BW = W + BOOST_HEAD;
    localparam int SW = BW + 1;
    localparam int LVL_W = $clog2(DEPTH + 1);
    localparam logic signed [W-1:0] FULL_POS = {1'b0, {(W-1){1'b1}}};
    localparam logic signed [W-1:0] FULL_NEG = {1'b1, {(W-1){1'b0}}};

    // Control registers
    logic [1:0] boost_reg;
    logic lsel_reg;
    logic rsel_reg;
    logic [3:0] latt_reg;
    logic [3:0] ratt_reg;
    logic [1:0] lsrc_reg;
    logic [1:0] rsrc_reg;
    logic [CHAN_N-1:0] clip_reg;
    logic [15:0] count_reg;

    // Held sidetone samples
    logic signed [W-1:0] hold_left_reg;
    logic signed [W-1:0] hold_right_reg;

    // Stage A
    logic a_valid_reg;
    logic signed [BW-1:0] a_boost_reg [CHAN_N];
    logic signed [W-1:0] a_side_reg [CHAN_N];

    // Per-channel views
    logic chan_sel [CHAN_N];
    logic [3:0] chan_att [CHAN_N];
    logic [1:0] chan_src [CHAN_N];
    logic signed [W-1:0] pick [CHAN_N];
    logic signed [BW-1:0] boosted [CHAN_N];
    logic signed [W-1:0] side_pick [CHAN_N];
    logic signed [W-1:0] side_scaled [CHAN_N];
    logic signed [SW-1:0] sum [CHAN_N];
    logic signed [W-1:0] sat [CHAN_N];
    logic [CHAN_N-1:0] clip_now;

    // Flow control
    logic take;
    logic a_pop;
    logic a_valid_next;
    logic buf_in_ready;
    logic [LVL_W-1:0] buf_level;

    // APB
    logic apb_setup;
    logic apb_write;
    logic [31:0] rd_value;
    logic rd_hit;
    logic [15:0] aif_word;
    logic [15:0] side_word;
    logic [15:0] status_word;
    logic hit_aif;
    logic hit_side;
    logic hit_status;
    logic hit_count;
    logic wr_lane0;
    logic wr_lane1;
    logic [CHAN_N-1:0] clip_clear;

    assign chan_sel[0] = lsel_reg;
    assign chan_sel[1] = rsel_reg;
    assign chan_att[0] = latt_reg;
    assign chan_att[1] = ratt_reg;
    assign chan_src[0] = lsrc_reg;
    assign chan_src[1] = rsrc_reg;

    assign take = play_valid && play_ready;
    assign a_pop = a_valid_reg && buf_in_ready;
    assign a_valid_next = (a_valid_reg && !a_pop) || take;

    // Sidetone taps from the high-pass filter output
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            hold_left_reg <= '0;
            hold_right_reg <= '0;
        end else if (side_valid) begin
            hold_left_reg <= side_left_sample;
            hold_right_reg <= side_right_sample;
        end
    end

    for (genvar c = 0; c < CHAN_N; c++) begin : g_chan
        // Interface channel select
        always_comb begin
            pick[c] = chan_sel[c] ? play_right_sample : play_left_sample;
        end

        // Power-of-two boost, 6 dB per step
        always_comb begin
            boosted[c] = BW'(pick[c]) <<< boost_reg;
        end

        // Source select, muted when rates differ
        always_comb begin
            side_pick[c] = '0;
            if (rates_match) begin
                unique case (chan_src[c])
                    SRC_ADC_LEFT: side_pick[c] = hold_left_reg;
                    SRC_ADC_RIGHT: side_pick[c] = hold_right_reg;
                    default: side_pick[c] = '0;
                endcase
            end
        end

        dbsm_side_atten #(
            .W(W)
        ) u_atten (
            .sample(side_pick[c]),
            .code(chan_att[c]),
            .scaled(side_scaled[c])
        );

        always_ff @(posedge clk_sys) begin
            if (take) begin
                a_boost_reg[c] <= boosted[c];
                a_side_reg[c] <= side_scaled[c];
            end
        end

        // Boost already applied, attenuated sidetone added without boost
        always_comb begin
            sum[c] = SW'(a_boost_reg[c]) + SW'(a_side_reg[c]);
        end

        // Clamp instead of wrapping
        always_comb begin
            clip_now[c] = 1'b0;
            sat[c] = sum[c][W-1:0];
            if (sum[c] > SW'(FULL_POS)) begin
                sat[c] = FULL_POS;
                clip_now[c] = 1'b1;
            end else if (sum[c] < SW'(FULL_NEG)) begin
                sat[c] = FULL_NEG;
                clip_now[c] = 1'b1;
            end
        end
    end

    // Stage A occupancy and registered ready
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            a_valid_reg <= 1'b0;
            play_ready <= 1'b0;
        end else begin
            a_valid_reg <= a_valid_next;
            play_ready <= !a_valid_next;
        end
    end

    dbsm_pair_buf #(
        .WIDTH(2 * W),
        .DEPTH(DEPTH)
    ) u_buf (
        .clk_sys(clk_sys),
        .reset(reset),
        .in_valid(a_valid_reg),
        .in_data({sat[0], sat[1]}),
        .in_ready(buf_in_ready),
        .out_valid(dac_valid),
        .out_data({dac_left_sample, dac_right_sample}),
        .out_ready(dac_ready),
        .level(buf_level)
    );

    // Mixed sample counter
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            count_reg <= '0;
        end else if (a_pop) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    // APB decode
    assign apb_setup = psel && !penable;
    assign apb_write = psel && penable && pready && pwrite;

    // Address hits shared by reads and writes
    assign hit_aif = (paddr == OFF_AIF_CFG);
    assign hit_side = (paddr == OFF_SIDE_CTL);
    assign hit_status = (paddr == OFF_STATUS);
    assign hit_count = (paddr == OFF_COUNT);
    assign rd_hit = hit_aif || hit_side || hit_status || hit_count;
    assign wr_lane0 = apb_write && pstrb[0];
    assign wr_lane1 = apb_write && pstrb[1];
    assign clip_clear = (wr_lane0 && hit_status) ? pwdata[ST_CLIP_LSB+:CHAN_N] : '0;

    assign aif_word = {10'h000, lsel_reg, rsel_reg, 2'h0, boost_reg};
    assign side_word = {4'h0, latt_reg, ratt_reg, lsrc_reg, rsrc_reg};

    // Status fields placed by position
    always_comb begin
        status_word = '0;
        status_word[ST_CLIP_LSB+:CHAN_N] = clip_reg;
        status_word[ST_MATCH_BIT] = rates_match;
        status_word[ST_LEVEL_LSB+:LVL_W] = buf_level;
    end

    always_comb begin
        rd_value = '0;
        unique case (paddr)
            OFF_AIF_CFG: rd_value = {16'h0000, aif_word};
            OFF_SIDE_CTL: rd_value = {16'h0000, side_word};
            OFF_STATUS: rd_value = {16'h0000, status_word};
            OFF_COUNT: rd_value = {16'h0000, count_reg};
            default: rd_value = '0;
        endcase
    end

    // One-cycle answer per transfer
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pready <= 1'b0;
        end else begin
            pready <= apb_setup;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= apb_setup && !rd_hit;
        end
    end

    // Read data stands only in the access cycle
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            prdata <= '0;
        end else if (apb_setup && !pwrite) begin
            prdata <= rd_value;
        end else begin
            prdata <= '0;
        end
    end

    // Boost field
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            boost_reg <= BOOST_RST;
        end else if (wr_lane0 && hit_aif) begin
            boost_reg <= pwdata[BOOST_LSB+:2];
        end
    end

    // Interface channel selects
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            lsel_reg <= LSEL_RST;
            rsel_reg <= RSEL_RST;
        end else if (wr_lane0 && hit_aif) begin
            lsel_reg <= pwdata[LSEL_BIT];
            rsel_reg <= pwdata[RSEL_BIT];
        end
    end

    // Sidetone attenuations, per byte lane
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            latt_reg <= ATT_RST;
            ratt_reg <= ATT_RST;
        end else if (hit_side) begin
            if (wr_lane1) begin
                latt_reg <= pwdata[LATT_LSB+:4];
            end
            if (wr_lane0) begin
                ratt_reg <= pwdata[RATT_LSB+:4];
            end
        end
    end

    // Sidetone sources
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            lsrc_reg <= SRC_RST;
            rsrc_reg <= SRC_RST;
        end else if (wr_lane0 && hit_side) begin
            lsrc_reg <= pwdata[LSRC_LSB+:2];
            rsrc_reg <= pwdata[RSRC_LSB+:2];
        end
    end

    // Sticky clip flags, write one to clear, set wins
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            clip_reg <= '0;
        end else begin
            for (int i = 0; i < CHAN_N; i++) begin
                if (a_pop && clip_now[i]) begin
                    clip_reg[i] <= 1'b1;
                end else if (clip_clear[i]) begin
                    clip_reg[i] <= 1'b0;
                end
            end
        end
    end
endmodule : dbsm_top

// ---- bench/dbsm_top_props.sv ----
`timescale 1ns/1ps
module dbsm_top_props
    import dbsm_pkg::*;
#(
    parameter int W = SAMPLE_W
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic play_valid,
    input wire logic play_ready,
    input wire logic signed [W-1:0] dac_left_sample,
    input wire logic signed [W-1:0] dac_right_sample,
    input wire logic dac_valid,
    input wire logic dac_ready
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_setup_answer: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside access");
    a_upper_half: assert property (pready |-> prdata[31:16] == 16'h0)
        else $error("upper read half not zero");
    a_take_once: assert property (play_valid && play_ready |=> !play_ready)
        else $error("second take without pause");
    a_out_after_take: assert property (
        play_valid && play_ready && !dac_valid |-> ##[1:2] dac_valid)
        else $error("mixed pair late");
    a_dac_hold: assert property (dac_valid && !dac_ready |=>
        dac_valid && $stable(dac_left_sample) && $stable(dac_right_sample))
        else $error("output pair changed while stalled");
    c_take: cover property (play_valid && play_ready);
    c_stall: cover property (dac_valid && !dac_ready);
    c_err: cover property (pslverr);
endmodule : dbsm_top_props
bind dbsm_top dbsm_top_props #(.W(W)) i_dbsm_top_props (.clk_sys(clk_sys), .reset(reset),
    .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .play_valid(play_valid), .play_ready(play_ready), .dac_left_sample(dac_left_sample),
    .dac_right_sample(dac_right_sample), .dac_valid(dac_valid), .dac_ready(dac_ready));

// ---- bench/dbsm_host_model.sv ----
`timescale 1ns/1ps
module dbsm_host_model
    import dbsm_pkg::*;
#(
    parameter int W = SAMPLE_W
) (
    input wire logic clk_sys,
    input wire logic play_ready,
    output logic signed [W-1:0] play_left_sample,
    output logic signed [W-1:0] play_right_sample,
    output logic play_valid
);
    int n_timeout = 0;
    initial begin
        play_valid = 1'b0;
        play_left_sample = '0;
        play_right_sample = '0;
    end
    // Offer one pair, hold until taken, scramble idle lines
    task automatic send(input logic [W-1:0] l, input logic [W-1:0] r);
        int n;
        @(posedge clk_sys);
        play_left_sample <= l;
        play_right_sample <= r;
        play_valid <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (play_ready !== 1'b1 && n < 200);
        if (play_ready !== 1'b1) begin
            n_timeout++;
        end
        play_valid <= 1'b0;
        play_left_sample <= ~l;
        play_right_sample <= ~r;
    endtask : send
endmodule : dbsm_host_model

// ---- bench/dac_boost_and_sidetone_mixer_tb.sv ----
`timescale 1ns/1ps
module dac_boost_and_sidetone_mixer_tb;
    import dbsm_pkg::*;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic signed [SAMPLE_W-1:0] play_left_sample, play_right_sample;
    logic signed [SAMPLE_W-1:0] dac_left_sample, dac_right_sample;
    logic signed [SAMPLE_W-1:0] side_left_sample = '0;
    logic signed [SAMPLE_W-1:0] side_right_sample = '0;
    logic play_valid, play_ready, dac_valid;
    logic side_valid = 1'b0;
    logic rates_match = 1'b1;
    logic dac_ready = 1'b1;
    int n_fail = 0;
    int compares = 0;
    always #5 clk_sys = ~clk_sys;
    dbsm_top #(.W(SAMPLE_W), .DEPTH(BUF_DEPTH)) i_dbsm_top (.clk_sys(clk_sys), .reset(reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .play_left_sample(play_left_sample), .play_right_sample(play_right_sample),
        .play_valid(play_valid), .play_ready(play_ready), .side_left_sample(side_left_sample),
        .side_right_sample(side_right_sample), .side_valid(side_valid),
        .rates_match(rates_match), .dac_left_sample(dac_left_sample),
        .dac_right_sample(dac_right_sample), .dac_valid(dac_valid), .dac_ready(dac_ready));
    dbsm_host_model #(.W(SAMPLE_W)) i_dbsm_host_model (.clk_sys(clk_sys),
        .play_ready(play_ready), .play_left_sample(play_left_sample),
        .play_right_sample(play_right_sample), .play_valid(play_valid));
    task automatic complete_run;
        n_fail += i_dbsm_host_model.n_timeout;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic er);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            n_fail++;
            complete_run();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic er;
        apb(1'b1, a, d, rd, er);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic er;
        apb(1'b0, a, 32'h0, rd, er);
        chk(rd, exp);
        chk({31'h0, er}, 32'h0);
    endtask : rd_chk
    task automatic get(input logic [23:0] el, input logic [23:0] er);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (!(dac_valid === 1'b1 && dac_ready === 1'b1) && n < 50);
        if (!(dac_valid === 1'b1 && dac_ready === 1'b1)) begin
            n_fail++;
            complete_run();
        end
        chk({8'h0, dac_left_sample}, {8'h0, el});
        chk({8'h0, dac_right_sample}, {8'h0, er});
    endtask : get
    task automatic mix(input logic [23:0] l, input logic [23:0] r, input logic [23:0] el,
        input logic [23:0] er);
        i_dbsm_host_model.send(l, r);
        get(el, er);
    endtask : mix
    task automatic t_regs;
        logic [31:0] rd;
        logic er;
        rd_chk(OFF_AIF_CFG, 32'h10);
        rd_chk(OFF_SIDE_CTL, 32'h0);
        wr(OFF_SIDE_CTL, 32'hffff);
        rd_chk(OFF_SIDE_CTL, 32'h0fff);
        apb(1'b1, 8'h40, 32'h5, rd, er);
        chk({31'h0, er}, 32'h1);
        wr(OFF_SIDE_CTL, 32'h0);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_boost;
        for (int b = 0; b < 4; b++) begin
            wr(OFF_AIF_CFG, 32'h10 | b);
            mix(24'h001234, 24'hffedcc, 24'h001234 << b, 24'hffedcc << b);
        end
        wr(OFF_AIF_CFG, 32'h20);
        mix(24'h000111, 24'h000222, 24'h000222, 24'h000111);
        $display("t_boost done");
    endtask : t_boost
    task automatic t_side;
        logic [23:0] s;
        side_left_sample <= 24'h000100;
        side_right_sample <= 24'h000020;
        side_valid <= 1'b1;
        @(posedge clk_sys);
        side_valid <= 1'b0;
        for (int c = 0; c < 4; c++) begin
            s = (c == 1) ? 24'h000100 : (c == 2) ? 24'h000020 : 24'h0;
            wr(OFF_AIF_CFG, 32'h10 | (c & 1));
            wr(OFF_SIDE_CTL, 32'hcc0 | (c << 2) | c);
            mix(24'h001000, 24'h002000, (24'h001000 << (c & 1)) + s,
                (24'h002000 << (c & 1)) + s);
        end
        wr(OFF_SIDE_CTL, 32'hcc5);
        rates_match <= 1'b0;
        mix(24'h001000, 24'h002000, 24'h002000, 24'h004000);
        rates_match <= 1'b1;
        wr(OFF_AIF_CFG, 32'h13);
        mix(24'h400000, 24'hc00000, 24'h7fffff, 24'h800000);
        rd_chk(OFF_STATUS, 32'h00000007);
        wr(OFF_STATUS, 32'h00000003);
        rd_chk(OFF_STATUS, 32'h00000004);
        rd_chk(OFF_COUNT, 32'h0000000b);
        side_left_sample <= 24'h008000;
        side_right_sample <= 24'h008000;
        side_valid <= 1'b1;
        @(posedge clk_sys);
        side_valid <= 1'b0;
        wr(OFF_AIF_CFG, 32'h10);
        wr(OFF_SIDE_CTL, 32'h0b5);
        mix(24'h0, 24'h0, 24'($rtoi(32768.0 * 10.0 ** (-36.0 / 20.0) + 0.5)),
            24'($rtoi(32768.0 * 10.0 ** (-3.0 / 20.0) + 0.5)));
        $display("t_side done");
    endtask : t_side
    task automatic t_stall;
        wr(OFF_SIDE_CTL, 32'h0);
        wr(OFF_AIF_CFG, 32'h10);
        dac_ready <= 1'b0;
        for (int i = 1; i < 4; i++)
            i_dbsm_host_model.send(24'(i), 24'(i + 8));
        @(posedge clk_sys);
        chk({31'h0, play_ready}, 32'h0);
        dac_ready <= 1'b1;
        for (int i = 1; i < 4; i++)
            get(24'(i), 24'(i + 8));
        $display("t_stall done");
    endtask : t_stall
    initial begin
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        t_regs();
        t_boost();
        t_side();
        t_stall();
        complete_run();
    end
endmodule : dac_boost_and_sidetone_mixer_tb
